/* File: design/hs_pkg.sv */
package hs_pkg;

  // Encoder phase between two adjacent stopper origin candidates.
  localparam int            PHASE_W        = 10;
  localparam logic [9:0]    PHASE_MAX      = 10'h3e7;
  localparam int            CANDS_PER_REV  = 50;
  localparam int            SPD_W          = 16;
  localparam int            POS_W          = 32;

  // Method setting: the upper bits pick the kind, bit 0 marks auto start.
  localparam logic [3:0]    METHOD_MAX     = 4'h9;
  localparam logic [2:0]    KIND_STOPPER   = 3'h0;
  localparam logic [2:0]    KIND_SENSOR    = 3'h1;
  localparam logic [2:0]    KIND_STOPPER_Z = 3'h2;
  localparam logic [2:0]    KIND_SENSOR_Z  = 3'h3;
  localparam logic [2:0]    KIND_Z_ONLY    = 3'h4;

  // First input line functions.
  localparam logic [1:0]    IN1_ORIGIN     = 2'h1;
  localparam logic [1:0]    IN1_LIMIT_CCW  = 2'h2;
  localparam logic [1:0]    IN1_LIMIT_CW   = 2'h3;

  // Stopper slow-down is speed / 16.
  localparam int            SLOW_SHIFT     = 4;

  // Offset unit scale factors.
  localparam logic [31:0]   OFFS_SCALE_0   = 32'h0000_0001;
  localparam logic [31:0]   OFFS_SCALE_1   = 32'h0000_000a;
  localparam logic [31:0]   OFFS_SCALE_2   = 32'h0000_0064;
  localparam logic [31:0]   OFFS_SCALE_3   = 32'h0000_03e8;

  // Motion status word and warning codes.
  localparam logic [15:0]   ST_MOVING      = 16'h0000;
  localparam logic [15:0]   ST_INPOS       = 16'h0008;
  localparam logic [15:0]   ST_WARN        = 16'h0100;
  localparam logic [7:0]    WARN_NONE      = 8'h00;
  localparam logic [7:0]    WARN_ORIGIN    = 8'h20;

  typedef enum logic [1:0]
  {
    HS_OP_RUN  = 2'h0,
    HS_OP_STOP = 2'h1,
    HS_OP_GOTO = 2'h2
  } hs_op_t;

  typedef struct packed
  {
    hs_op_t                   op;
    logic                     dir;
    logic [SPD_W-1:0]         speed;
    logic [SPD_W-1:0]         accel;
    logic signed [POS_W-1:0]  target;
  } hs_cmd_t;

  typedef struct packed
  {
    logic [3:0]               method;
    logic [SPD_W-1:0]         speed;
    logic [SPD_W-1:0]         accel;
    logic                     dir;
    logic signed [POS_W-1:0]  offset;
    logic [1:0]               offset_unit;
    logic [7:0]               torque_thr;
    logic [1:0]               in1_func;
  } hs_cfg_t;

  typedef struct packed
  {
    logic [7:0]               torque_pct;
    logic [SPD_W-1:0]         speed_mag;
    logic [PHASE_W-1:0]       phase;
    logic signed [POS_W-1:0]  position;
  } hs_fb_t;

endpackage

/* File: design/hs_pin_sync.sv */
module hs_pin_sync
#(
  parameter int W = 3
)
(
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Asynchronous pins in, clean levels and edges out.
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] prev_q;

  // The first stage feeds only the second; edges compare stages two and three.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_q  <= '0;
      level_o <= '0;
      prev_q  <= '0;
    end
    else
    begin
      meta_q  <= pin_i;
      level_o <= meta_q;
      prev_q  <= level_o;
    end
  end

  assign rise_o = level_o & ~prev_q;
  assign fall_o = ~level_o & prev_q;

endmodule

/* File: design/hs_sequencer.sv */
module hs_sequencer
(
  // Clock and reset.
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  // Host side: configuration and start.
  input  wire hs_pkg::hs_cfg_t             cfg_i,
  input  wire logic                        start_i,
  // Motion side: feedback and completion of the last command.
  input  wire hs_pkg::hs_fb_t              fb_i,
  input  wire logic                        motion_done_i,
  // Pins from outside the clock domain.
  input  wire logic                        first_input_line_i,
  input  wire logic                        limit_home_dir_i,
  input  wire logic                        z_pulse_i,
  // Motion commands.
  output hs_pkg::hs_cmd_t                  cmd_o,
  output logic                             cmd_valid_o,
  // Results and status.
  output logic [hs_pkg::PHASE_W-1:0]       stopper_phase_o,
  output logic                             stopper_phase_valid_o,
  output logic signed [hs_pkg::POS_W-1:0]  origin_pos_o,
  output logic                             origin_set_o,
  output logic                             busy_o,
  output logic                             done_o,
  output logic [15:0]                      motion_status_word_o,
  output logic [7:0]                       warning_code_o
);
  import hs_pkg::*;

  typedef enum logic [3:0]
  {
    S_IDLE      = 4'h0,
    S_CHECK     = 4'h1,
    S_SEEK      = 4'h3,
    S_SEEK_STOP = 4'h2,
    S_RETURN    = 4'h6,
    S_ZSEEK     = 4'h7,
    S_ZSTOP     = 4'h5,
    S_FINISH    = 4'h4,
    S_ESCAPE    = 4'hc,
    S_ESC_STOP  = 4'hd,
    S_LIMIT_REV = 4'hf,
    S_WARN      = 4'he
  } hs_state_t;

  hs_state_t               state_q;
  hs_state_t               state_d;
  hs_cmd_t                 cmd_d;
  logic                    cmd_go;
  logic                    cap_seek;
  logic                    cap_z;
  logic                    auto_q;
  logic                    start_ok;
  logic [2:0]              kind;
  logic                    uses_sensor;
  logic                    uses_stopper;
  logic                    with_z;
  logic                    hit;
  logic                    slow;
  logic [SPD_W-1:0]        slow_lim;
  logic                    sens_lvl;
  logic                    sens_rise;
  logic                    sens_fall;
  logic                    lim_lvl;
  logic                    z_rise;
  logic [2:0]              pin_lvl;
  logic [2:0]              pin_rise;
  logic [2:0]              pin_fall;
  logic signed [POS_W-1:0] edge_pos_q;
  logic signed [POS_W-1:0] base_pos_q;

  hs_pin_sync
  #(
    .W (3)
  )
  u_sync
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   ({z_pulse_i, limit_home_dir_i, first_input_line_i}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  assign sens_lvl  = pin_lvl[0];
  assign sens_rise = pin_rise[0];
  assign sens_fall = pin_fall[0];
  assign lim_lvl   = pin_lvl[1];
  assign z_rise    = pin_rise[2];

  // Method decoding.
  function automatic logic [2:0] method_kind(input logic [3:0] m);
    method_kind = m[3:1];
  endfunction

  // Offset scaled by its unit.
  function automatic logic signed [POS_W-1:0] scaled_offset
  (
    input logic signed [POS_W-1:0] off,
    input logic [1:0]              unit
  );
    logic [31:0] k;
    k = OFFS_SCALE_0;
    case (unit)
      2'h1:    k = OFFS_SCALE_1;
      2'h2:    k = OFFS_SCALE_2;
      2'h3:    k = OFFS_SCALE_3;
      default: k = OFFS_SCALE_0;
    endcase
    scaled_offset = POS_W'(off * $signed(k));
  endfunction

  // One command image built from the configured motion settings.
  function automatic hs_cmd_t make_cmd
  (
    input hs_op_t                  op,
    input logic                    dir,
    input logic [SPD_W-1:0]        spd,
    input logic [SPD_W-1:0]        acc,
    input logic signed [POS_W-1:0] tgt
  );
    make_cmd.op     = op;
    make_cmd.dir    = dir;
    make_cmd.speed  = spd;
    make_cmd.accel  = acc;
    make_cmd.target = tgt;
  endfunction

  assign kind         = method_kind(cfg_i.method);
  assign uses_sensor  = (kind == KIND_SENSOR) || (kind == KIND_SENSOR_Z);
  assign uses_stopper = (kind == KIND_STOPPER) || (kind == KIND_STOPPER_Z);
  assign with_z       = (kind == KIND_STOPPER_Z) || (kind == KIND_SENSOR_Z);

  // A command start, or one automatic start after reset for odd methods.
  assign start_ok = (cfg_i.method <= METHOD_MAX)
                  && (start_i || (auto_q && cfg_i.method[0]));

  // Torque and speed feedback are same-clock values; the motor is
  // considered stalled once its torque reaches the threshold and it has slowed to a sixteenth of the set speed.
  assign slow_lim = cfg_i.speed >> SLOW_SHIFT;
  assign slow     = fb_i.speed_mag <= slow_lim;
  always_comb
  begin
    hit = 1'b0;
    case (kind)
      KIND_STOPPER,
      KIND_STOPPER_Z: hit = (fb_i.torque_pct >= cfg_i.torque_thr) && slow;
      KIND_SENSOR,
      KIND_SENSOR_Z:  hit = sens_rise;
      KIND_Z_ONLY:    hit = z_rise;
      default:        hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      auto_q <= 1'b1;
    else if (state_q == S_IDLE)
      auto_q <= 1'b0;
  end

  always_comb
  begin
    state_d  = state_q;
    cmd_go   = 1'b0;
    cmd_d    = cmd_o;
    cap_seek = 1'b0;
    cap_z    = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        if (start_ok)
          state_d = S_CHECK;
      end
      S_CHECK:
      begin
        cmd_go = 1'b1;
        if (uses_sensor && (cfg_i.in1_func != IN1_ORIGIN))
        begin
          cmd_go  = 1'b0;
          state_d = S_WARN;
        end
        else if (uses_sensor && sens_lvl)
        begin
          state_d = S_ESCAPE;
          cmd_d   = make_cmd(HS_OP_RUN, ~cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
        end
        else
        begin
          state_d = S_SEEK;
          cmd_d   = make_cmd(HS_OP_RUN, cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
        end
      end
      S_SEEK:
      begin
        if (uses_sensor && lim_lvl)
        begin
          state_d = S_LIMIT_REV;
          cmd_go  = 1'b1;
          cmd_d   = make_cmd(HS_OP_RUN, ~cfg_i.dir, SPD_W'(cfg_i.speed << 1),
                             cfg_i.accel, '0);
        end
        else if (hit)
        begin
          state_d  = S_SEEK_STOP;
          cap_seek = 1'b1;
          cmd_go   = 1'b1;
          cmd_d    = make_cmd(HS_OP_STOP, cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
        end
      end
      S_LIMIT_REV:
      begin
        if (sens_lvl)
        begin
          state_d = S_ESCAPE;
          cmd_go  = 1'b1;
          cmd_d   = make_cmd(HS_OP_RUN, ~cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
        end
      end
      S_ESCAPE:
      begin
        if (sens_fall)
        begin
          state_d = S_ESC_STOP;
          cmd_go  = 1'b1;
          cmd_d   = make_cmd(HS_OP_STOP, ~cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
        end
      end
      S_ESC_STOP:
      begin
        if (motion_done_i)
        begin
          state_d = S_SEEK;
          cmd_go  = 1'b1;
          cmd_d   = make_cmd(HS_OP_RUN, cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
        end
      end
      S_SEEK_STOP:
      begin
        if (motion_done_i)
        begin
          if (uses_sensor)
          begin
            state_d = S_RETURN;
            cmd_go  = 1'b1;
            cmd_d   = make_cmd(HS_OP_GOTO, cfg_i.dir, cfg_i.speed, cfg_i.accel,
                               edge_pos_q);
          end
          else if (with_z)
          begin
            state_d = S_ZSEEK;
            cmd_go  = 1'b1;
            cmd_d   = make_cmd(HS_OP_RUN, ~cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
          end
          else
            state_d = S_FINISH;
        end
      end
      S_RETURN:
      begin
        if (motion_done_i)
        begin
          if (with_z)
          begin
            state_d = S_ZSEEK;
            cmd_go  = 1'b1;
            cmd_d   = make_cmd(HS_OP_RUN, ~cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
          end
          else
            state_d = S_FINISH;
        end
      end
      S_ZSEEK:
      begin
        if (z_rise)
        begin
          state_d = S_ZSTOP;
          cap_z   = 1'b1;
          cmd_go  = 1'b1;
          cmd_d   = make_cmd(HS_OP_STOP, ~cfg_i.dir, cfg_i.speed, cfg_i.accel, '0);
        end
      end
      S_ZSTOP:
      begin
        if (motion_done_i)
          state_d = S_FINISH;
      end
      S_FINISH: state_d = S_IDLE;
      S_WARN:   state_d = S_IDLE;
      default:  state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= S_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_o       <= '0;
      cmd_valid_o <= 1'b0;
    end
    else
    begin
      cmd_o       <= cmd_d;
      cmd_valid_o <= cmd_go;
    end
  end

  // Capture of the stopper phase and of the reference positions. The
  // stopper origin is the phase-0 point of the cycle the stall fell in,
  // so without a Z search it does not depend on where the Z pulse lies; with one, the Z edge position replaces it.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      edge_pos_q            <= '0;
      base_pos_q            <= '0;
      stopper_phase_o       <= '0;
      stopper_phase_valid_o <= 1'b0;
    end
    else if (cap_seek)
    begin
      edge_pos_q <= fb_i.position;
      if (uses_stopper)
      begin
        stopper_phase_o       <= fb_i.phase;
        stopper_phase_valid_o <= 1'b1;
        base_pos_q            <= fb_i.position - POS_W'(fb_i.phase);
      end
      else
        base_pos_q <= fb_i.position;
    end
    else if (cap_z)
      base_pos_q <= fb_i.position;
    else if (state_q == S_IDLE && start_ok)
      stopper_phase_valid_o <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      origin_pos_o <= '0;
      origin_set_o <= 1'b0;
    end
    else
    begin
      origin_set_o <= (state_q == S_FINISH);
      if (state_q == S_FINISH)
      begin
        if (kind == KIND_Z_ONLY)
          origin_pos_o <= base_pos_q;
        else
          origin_pos_o <= base_pos_q
                        + scaled_offset(cfg_i.offset, cfg_i.offset_unit);
      end
    end
  end

  // Busy covers the whole run; done holds until the next start.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_o               <= 1'b0;
      done_o               <= 1'b0;
      motion_status_word_o <= ST_INPOS;
      warning_code_o       <= WARN_NONE;
    end
    else
    begin
      // The warning pass keeps busy up until the warning status shows, so the
      // host never sees an idle flag next to a moving status word.
      busy_o <= (state_d != S_IDLE);
      if (state_q == S_IDLE && start_ok)
      begin
        done_o               <= 1'b0;
        motion_status_word_o <= ST_MOVING;
        warning_code_o       <= WARN_NONE;
      end
      else if (state_q == S_WARN)
      begin
        motion_status_word_o <= ST_WARN | ST_INPOS;
        warning_code_o       <= WARN_ORIGIN;
      end
      else if (state_q == S_FINISH)
      begin
        done_o               <= 1'b1;
        motion_status_word_o <= ST_INPOS;
      end
    end
  end

endmodule

/* File: tb/hs_seq_sva.sv */
module hs_seq_sva
(
  // Clock and reset.
  input wire logic                       clk_i,
  input wire logic                       rst_b_i,
  // Watched inputs.
  input wire hs_pkg::hs_cfg_t            cfg_i,
  input wire logic                       start_i,
  input wire hs_pkg::hs_fb_t             fb_i,
  // Watched outputs.
  input wire hs_pkg::hs_cmd_t            cmd_o,
  input wire logic                       cmd_valid_o,
  input wire logic [hs_pkg::PHASE_W-1:0] stopper_phase_o,
  input wire logic                       stopper_phase_valid_o,
  input wire logic                       origin_set_o,
  input wire logic                       busy_o,
  input wire logic                       done_o,
  input wire logic [15:0]                motion_status_word_o,
  input wire logic [7:0]                 warning_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import hs_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Sensor kinds have bit 1 set; they need the first input line as origin sensor.
  logic good_setup;
  logic bad_setup;
  assign good_setup = cfg_i.method <= METHOD_MAX
                    && (!cfg_i.method[1] || cfg_i.in1_func == IN1_ORIGIN);
  assign bad_setup  = cfg_i.method <= METHOD_MAX && cfg_i.method[1]
                    && cfg_i.in1_func != IN1_ORIGIN;

  sequence start_req;
    !busy_o && !origin_set_o && start_i;
  endsequence

  sequence warn_shown;
    warning_code_o == WARN_ORIGIN && motion_status_word_o == (ST_WARN | ST_INPOS);
  endsequence

  start_cmd_a: assert property (start_req ##0 good_setup |-> ##[1:3] cmd_valid_o)
    else $error("accepted start gave no command");
  sensor_setup_a: assert property (start_req ##0 bad_setup |-> ##[2:3] warn_shown)
    else $error("missing origin setup warning");
  warn_pair_a: assert property (warning_code_o != WARN_NONE |-> warn_shown)
    else $error("warning code without warning status");
  idle_status_a: assert property (!busy_o && warning_code_o == WARN_NONE
                                  |-> motion_status_word_o == ST_INPOS)
    else $error("idle status wrong");
  busy_status_a: assert property (busy_o |-> motion_status_word_o == ST_MOVING)
    else $error("busy status wrong");
  done_hold_a: assert property (done_o && !start_i |=> done_o)
    else $error("completion dropped without start");
  origin_done_a: assert property (origin_set_o
                                  |-> done_o && !busy_o && motion_status_word_o == ST_INPOS)
    else $error("origin set without completion");
  stopper_phase_a: assert property ($rose(stopper_phase_valid_o)
                                    |-> stopper_phase_o == $past(fb_i.phase)
                                        && stopper_phase_o <= PHASE_MAX)
    else $error("stopper phase capture wrong");
  run_cmd_a: assert property (cmd_valid_o && cmd_o.op == HS_OP_RUN
                              |-> cmd_o.accel == cfg_i.accel
                                  && (cmd_o.speed == cfg_i.speed
                                      || cmd_o.speed == (cfg_i.speed << 1)))
    else $error("run command speed or accel wrong");
  cmd_busy_a: assert property (cmd_valid_o |-> busy_o)
    else $error("command while idle");
endmodule

/* File: tb/hs_motor_model.sv */
module hs_motor_model
(
  // Clock and reset.
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  // Commands in.
  input  wire hs_pkg::hs_cmd_t cmd_i,
  input  wire logic            cmd_valid_i,
  // Feedback and pins out.
  output hs_pkg::hs_fb_t       fb_o,
  output logic                 motion_done_o,
  output logic                 sensor_o,
  output logic                 limit_o,
  output logic                 z_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import hs_pkg::*;

  // The stopper sits at phase 234, inside the band an installer should aim for.
  localparam logic signed [31:0] STOP_AT = 32'sh0000_04d2;
  localparam logic signed [31:0] SENS_LO = 32'sh0000_044c;
  localparam logic signed [31:0] SENS_HI = 32'sh0000_04b0;
  // The limit sits below the sensor, so it guards homing toward lower positions.
  localparam logic signed [31:0] LIM_AT  = 32'sh0000_0320;
  localparam hs_cmd_t CMD_REST = '{op: HS_OP_STOP, dir: 1'b0, speed: '0, accel: '0, target: '0};

  hs_cmd_t            cmd_q;
  logic [2:0]         tick_q;
  logic [3:0]         wait_q;
  logic signed [31:0] pos_q;
  logic [9:0]         phase;
  logic               run;
  logic               blocked;

  // One step every eight clocks keeps each pin level stable across the synchroniser.
  assign run      = cmd_q.op == HS_OP_RUN;
  assign blocked  = run && cmd_q.dir && pos_q >= STOP_AT;
  assign phase    = 10'(pos_q % 32'sh0000_03e8);
  assign fb_o     = {(blocked ? 8'h64 : 8'h00),
                     ((run && !blocked) ? cmd_q.speed : 16'h0000), phase, pos_q};
  assign sensor_o = pos_q >= SENS_LO && pos_q < SENS_HI;
  assign limit_o  = pos_q <= LIM_AT;
  assign z_o      = phase == 10'h000;

  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      cmd_q         <= CMD_REST;
      tick_q        <= 3'h0;
      wait_q        <= 4'h0;
      pos_q         <= 32'sh0000_0384;
      motion_done_o <= 1'b0;
    end
    else
    begin
      tick_q        <= tick_q + 3'h1;
      motion_done_o <= wait_q == 4'h1;
      if (cmd_valid_i)
      begin
        cmd_q  <= cmd_i;
        wait_q <= (cmd_i.op == HS_OP_RUN) ? 4'h0 : 4'h6;
      end
      else if (wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1 && cmd_q.op == HS_OP_GOTO)
        pos_q <= cmd_q.target;
      else if (run && !blocked && tick_q == 3'h7)
        pos_q <= cmd_q.dir ? pos_q + 32'sh1 : pos_q - 32'sh1;
    end
endmodule

/* File: tb/tb_top.sv */
`define CHK(act, exp) \
  begin \
    checked++; \
    if ((act) !== (exp)) \
    begin \
      miscompares++; \
      $display("[ERR] t=%0t act=%h exp=%h", $time, (act), (exp)); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hs_pkg::*;

  logic                    clk_i;
  logic                    rst_b_i;
  hs_cfg_t                 cfg;
  logic                    start;
  hs_fb_t                  fb;
  logic                    mdone;
  logic                    sensor;
  logic                    limit;
  logic                    zp;
  hs_cmd_t                 cmd;
  logic                    cmd_valid;
  logic [PHASE_W-1:0]      stop_phase;
  logic                    stop_valid;
  logic signed [POS_W-1:0] origin;
  logic                    origin_set;
  logic                    busy;
  logic                    done;
  logic [15:0]             status;
  logic [7:0]              warn;
  int                      miscompares = 0;
  int                      checked = 0;
  int                      cycles = 0;

  hs_sequencer dut_u
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg), .start_i(start), .fb_i(fb),
    .motion_done_i(mdone), .first_input_line_i(sensor), .limit_home_dir_i(limit),
    .z_pulse_i(zp), .cmd_o(cmd), .cmd_valid_o(cmd_valid), .stopper_phase_o(stop_phase),
    .stopper_phase_valid_o(stop_valid), .origin_pos_o(origin), .origin_set_o(origin_set),
    .busy_o(busy), .done_o(done), .motion_status_word_o(status), .warning_code_o(warn)
  );

  hs_motor_model model_u
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_i(cmd), .cmd_valid_i(cmd_valid), .fb_o(fb),
    .motion_done_o(mdone), .sensor_o(sensor), .limit_o(limit), .z_o(zp)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic start_home(input logic [3:0] m, input logic d, input logic signed [31:0] off,
                            input logic [1:0] u, input logic [1:0] in1);
    @(negedge clk_i);
    cfg.method      = m;
    cfg.dir         = d;
    cfg.offset      = off;
    cfg.offset_unit = u;
    cfg.in1_func    = in1;
    start           = 1'b1;
    @(negedge clk_i);
    start           = 1'b0;
  endtask

  task automatic wait_origin(input logic signed [31:0] exp_org);
    int n;
    n = 0;
    while (origin_set !== 1'b1 && n < 8000)
    begin
      @(negedge clk_i);
      n++;
    end
    `CHK(origin_set, 1'b1)
    `CHK(origin, exp_org)
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask

  // A long seek that never finishes is cut short here.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    cfg            = '0;
    cfg.method     = 4'h1;
    cfg.speed      = 16'h0100;
    cfg.accel      = 16'h0020;
    cfg.dir        = 1'b1;
    cfg.offset     = 32'sh0000_0005;
    cfg.offset_unit = 2'h1;
    cfg.torque_thr = 8'h32;
    cfg.in1_func   = IN1_ORIGIN;
    start          = 1'b0;
    rst_b_i        = 1'b0;
    repeat (10) @(negedge clk_i);
    `CHK(status, ST_INPOS)
    `CHK(done, 1'b0)
    rst_b_i = 1'b1;
    wait_origin(32'sh0000_041a);
    `CHK(stop_valid, 1'b1)
    `CHK(stop_phase, 10'h0ea)
    start_home(4'h4, 1'b1, 32'sh0000_0007, 2'h0, IN1_ORIGIN);
    @(negedge clk_i);
    `CHK(done, 1'b0)
    wait_origin(32'sh0000_03ef);
    start_home(4'h2, 1'b1, 32'sh0000_0007, 2'h0, IN1_ORIGIN);
    wait_origin(32'sh0000_0453);
    start_home(4'h2, 1'b1, 32'sh0000_0007, 2'h0, IN1_ORIGIN);
    wait_origin(32'sh0000_0453);
    start_home(4'h8, 1'b0, 32'sh0000_0007, 2'h0, IN1_ORIGIN);
    wait_origin(32'sh0000_03e8);
    // Homing downward runs into the limit first, reverses, escapes the sensor.
    start_home(4'h2, 1'b0, 32'sh0000_0007, 2'h0, IN1_ORIGIN);
    wait_origin(32'sh0000_04b6);
    start_home(4'hc, 1'b1, 32'sh0000_0007, 2'h0, IN1_ORIGIN);
    repeat (4) @(negedge clk_i);
    `CHK(busy, 1'b0)
    `CHK(done, 1'b1)
    start_home(4'h2, 1'b1, 32'sh0000_0007, 2'h0, 2'h0);
    repeat (4) @(negedge clk_i);
    `CHK(status, ST_WARN | ST_INPOS)
    `CHK(warn, WARN_ORIGIN)
    `CHK(busy, 1'b0)
    test_done();
  end
endmodule

bind hs_sequencer hs_seq_sva chk_u
(
  .clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i), .start_i(start_i), .fb_i(fb_i),
  .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .stopper_phase_o(stopper_phase_o),
  .stopper_phase_valid_o(stopper_phase_valid_o), .origin_set_o(origin_set_o),
  .busy_o(busy_o), .done_o(done_o), .motion_status_word_o(motion_status_word_o),
  .warning_code_o(warning_code_o)
);
